// ===== src/ohp_pkg.sv
package ohp_pkg;
    // Interface modes decoded from the two strap inputs.
    typedef enum logic [1:0] {
        OHP_MODE_68,
        OHP_MODE_80,
        OHP_MODE_SER,
        OHP_MODE_BAD
    } ohp_mode_type;

    // Strap encodings, given as {iface_sel_hi, iface_sel_lo}.
    localparam logic [1:0] OHP_STRAP_68 = 2'h2;
    localparam logic [1:0] OHP_STRAP_80 = 2'h3;
    localparam logic [1:0] OHP_STRAP_SER = 2'h0;

    // Bus layout.
    localparam int OHP_BUS_W = 8;
    localparam int OHP_SER_DATA_BIT = 1;
    localparam int OHP_SER_CLK_BIT = 0;
    localparam int OHP_SYNC_STAGES = 2;

    // Reset values.
    localparam logic [7:0] OHP_BYTE_RST = 8'h00;
    localparam logic [2:0] OHP_CNT_RST = 3'h0;
    localparam logic [2:0] OHP_CNT_LAST = 3'h7;
endpackage : ohp_pkg

// ===== src/ohp_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a vector of pin levels.
module ohp_sync
    import ohp_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Levels.
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // Both stages clear to zero under reset.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule : ohp_sync

// ===== src/ohp_host_port.sv
`timescale 1ns/1ps
// Function
// - Ignore all bus traffic unless select low
// - Reset low initialises controller state
// - Data/command high: byte is display data
// - Data/command low: byte goes to command
// - 68 mode: enable high with select starts
// - 80 mode: read strobe low starts read
// - Eight-bit bus, device drives only reads
// - Serial: bit1 data in, bit0 clock
// - Straps choose 68, 80 or serial mode
module ohp_host_port
    import ohp_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Host pins.
    input wire logic ext_reset_n_i,
    input wire logic host_select_n_i,
    input wire logic data_cmd_sel_i,
    input wire logic rw_dir_i,
    input wire logic enable_strobe_i,
    input wire logic iface_sel_lo_i,
    input wire logic iface_sel_hi_i,
    input wire logic [7:0] host_bus_i,
    output logic [7:0] host_bus_o,
    output logic host_bus_oe_n_o,
    // Controller side.
    input wire logic [7:0] rd_data_i,
    output logic rd_req_o,
    output logic rd_dc_o,
    output logic wr_valid_o,
    output logic wr_dc_o,
    output logic [7:0] wr_data_o,
    output logic init_o
);
    localparam int SW = 15;
    logic [SW-1:0] raw;
    logic [SW-1:0] syn;
    logic s_rst_n, s_cs_n, s_dc, s_rw, s_en, s_lo, s_hi;
    logic [7:0] s_bus;
    ohp_mode_type mode;

    assign raw = {ext_reset_n_i, host_select_n_i, data_cmd_sel_i,
                  rw_dir_i, enable_strobe_i, iface_sel_lo_i,
                  iface_sel_hi_i, host_bus_i};

    // Every pin passes two flip-flops before any logic looks at it.
    ohp_sync #(.W(SW)) u_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .async_i(raw),
        .sync_o(syn)
    );

    assign {s_rst_n, s_cs_n, s_dc, s_rw, s_en, s_lo, s_hi, s_bus} = syn;

    // Strap decode; an unlisted code is a dead mode.
    always_comb begin
        case ({s_hi, s_lo})
            OHP_STRAP_68: mode = OHP_MODE_68;
            OHP_STRAP_80: mode = OHP_MODE_80;
            OHP_STRAP_SER: mode = OHP_MODE_SER;
            default: mode = OHP_MODE_BAD;
        endcase
    end

    // Strobe and serial-clock history for edge finding.
    logic en_q, en_d, wr_q, wr_d, sck_q, sck_d;
    logic act_q, act_d;
    logic [7:0] sh_q, sh_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic wv_q, wv_d, wdc_q, wdc_d, rreq_q, rreq_d, rdc_q, rdc_d;
    logic oe_n_q, oe_n_d;
    logic sel, start68, end68, start80r, end80r, end80w, sck_rise;
    logic in_reset;

    assign in_reset = !s_rst_n;
    assign sel = !s_cs_n && !in_reset;
    assign start68 = mode == OHP_MODE_68 && sel && s_en && !en_q;
    assign end68 = mode == OHP_MODE_68 && sel && !s_en && en_q;
    assign start80r = mode == OHP_MODE_80 && sel && !s_en && en_q;
    assign end80r = mode == OHP_MODE_80 && s_en && !en_q && act_q;
    assign end80w = mode == OHP_MODE_80 && sel && s_rw && !wr_q;
    assign sck_rise = mode == OHP_MODE_SER && sel
                      && s_bus[OHP_SER_CLK_BIT] && !sck_q;

    // Next-state logic for the whole port.
    always_comb begin
        en_d = s_en;
        wr_d = s_rw;
        sck_d = s_bus[OHP_SER_CLK_BIT];
        act_d = act_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        wdat_d = wdat_q;
        wdc_d = wdc_q;
        wv_d = 1'b0;
        rreq_d = 1'b0;
        rdc_d = rdc_q;
        rdat_d = rdat_q;
        oe_n_d = oe_n_q;
        if (in_reset) begin
            act_d = 1'b0;
            cnt_d = OHP_CNT_RST;
            oe_n_d = 1'b1;
        end else begin
            // 68 mode: direction set by rw_dir; a read starts at enable rise, a write is latched at enable fall.
            if (start68 && s_rw) begin
                rreq_d = 1'b1;
                rdc_d = s_dc;
                rdat_d = rd_data_i;
                oe_n_d = 1'b0;
                act_d = 1'b1;
            end
            if (end68) begin
                act_d = 1'b0;
                oe_n_d = 1'b1;
                if (!s_rw) begin
                    wv_d = 1'b1;
                    wdat_d = s_bus;
                    wdc_d = s_dc;
                end
            end
            // 80 mode: read strobe low drives, write strobe rise captures.
            if (start80r) begin
                rreq_d = 1'b1;
                rdc_d = s_dc;
                rdat_d = rd_data_i;
                oe_n_d = 1'b0;
                act_d = 1'b1;
            end
            if (end80r) begin
                act_d = 1'b0;
                oe_n_d = 1'b1;
            end
            if (end80w) begin
                wv_d = 1'b1;
                wdat_d = s_bus;
                wdc_d = s_dc;
            end
            // Serial mode: shift in MSB first, D/C taken on the eighth bit.
            if (mode != OHP_MODE_SER || !sel) begin
                cnt_d = OHP_CNT_RST;
            end else if (sck_rise) begin
                sh_d = {sh_q[6:0], s_bus[OHP_SER_DATA_BIT]};
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == OHP_CNT_LAST) begin
                    wv_d = 1'b1;
                    wdat_d = {sh_q[6:0], s_bus[OHP_SER_DATA_BIT]};
                    wdc_d = s_dc;
                end
            end
            // Deselect or a switch to serial or dead mode releases the bus at once.
            if (!sel || mode == OHP_MODE_SER || mode == OHP_MODE_BAD) begin
                oe_n_d = 1'b1;
                act_d = 1'b0;
            end
        end
    end

    // Register stage; all outputs but init_o come straight from here.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_q <= 1'b0;
            wr_q <= 1'b1; // Strobe idles high, but the sync clears s_rw low, so a rise still shows when the pin level arrives after reset.
            sck_q <= 1'b0;
            act_q <= 1'b0;
            sh_q <= OHP_BYTE_RST;
            cnt_q <= OHP_CNT_RST;
            wdat_q <= OHP_BYTE_RST;
            wdc_q <= 1'b0;
            wv_q <= 1'b0;
            rreq_q <= 1'b0;
            rdc_q <= 1'b0;
            rdat_q <= OHP_BYTE_RST;
            oe_n_q <= 1'b1;
        end else begin
            en_q <= en_d;
            wr_q <= wr_d;
            sck_q <= sck_d;
            act_q <= act_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            wdat_q <= wdat_d;
            wdc_q <= wdc_d;
            wv_q <= wv_d;
            rreq_q <= rreq_d;
            rdc_q <= rdc_d;
            rdat_q <= rdat_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign host_bus_o = rdat_q;
    assign host_bus_oe_n_o = oe_n_q;
    assign wr_valid_o = wv_q;
    assign wr_dc_o = wdc_q;
    assign wr_data_o = wdat_q;
    assign rd_req_o = rreq_q;
    assign rd_dc_o = rdc_q;
    assign init_o = in_reset;

    // Checks.
    property p_cs_gate;
        @(posedge mclk_i) disable iff (!rst_b_i)
        s_cs_n |=> !wv_q && !rreq_q;
    endproperty
    a_cs_gate: assert property (p_cs_gate)
        else $error("transfer while deselected");

    property p_reset_idle;
        @(posedge mclk_i) disable iff (!rst_b_i)
        in_reset |=> oe_n_q && !wv_q && cnt_q == OHP_CNT_RST;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("activity during reset");

    property p_dc_data;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (end68 && !s_rw && s_dc) |=> wv_q && wdc_q;
    endproperty
    a_dc_data: assert property (p_dc_data)
        else $error("data byte not marked data");

    property p_dc_cmd;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (end80w && !s_dc) |=> wv_q && !wdc_q && wdat_q == $past(s_bus);
    endproperty
    a_dc_cmd: assert property (p_dc_cmd)
        else $error("command byte mishandled");

    property p_68_read;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (start68 && s_rw) |=> rreq_q && !oe_n_q;
    endproperty
    a_68_read: assert property (p_68_read)
        else $error("68 read not started");

    property p_80_read;
        @(posedge mclk_i) disable iff (!rst_b_i)
        start80r |=> rreq_q ##1 !rreq_q;
    endproperty
    a_80_read: assert property (p_80_read)
        else $error("80 read not started");

    property p_drive_only_read;
        @(posedge mclk_i) disable iff (!rst_b_i)
        $fell(oe_n_q) |-> $past(start68 || start80r);
    endproperty
    a_drive_only_read: assert property (p_drive_only_read)
        else $error("bus driven outside read");

    property p_serial_byte;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (sck_rise && cnt_q == OHP_CNT_LAST) |=> wv_q && cnt_q == OHP_CNT_RST;
    endproperty
    a_serial_byte: assert property (p_serial_byte)
        else $error("serial byte not delivered");

    property p_serial_no_drive;
        @(posedge mclk_i) disable iff (!rst_b_i)
        mode == OHP_MODE_SER |=> oe_n_q;
    endproperty
    a_serial_no_drive: assert property (p_serial_no_drive)
        else $error("bus driven in serial mode");
endmodule : ohp_host_port

// ===== test/ohp_host_model.sv
`timescale 1ns/1ps
// Host pin driver; the bench calls its tasks to build bus cycles.
module ohp_host_model (
    // Clock.
    input wire logic mclk_i,
    // Host pins.
    output logic select_n_o,
    output logic dc_o,
    output logic rw_o,
    output logic en_o,
    output logic [7:0] bus_o,
    output logic bus_en_o
);
    // Pins start idle and deselected.
    initial begin
        select_n_o = 1'h1;
        dc_o = 1'h0;
        rw_o = 1'h0;
        en_o = 1'h0;
        bus_o = 8'h00;
        bus_en_o = 1'h1;
    end

    // Pins change just after an edge and stand for n cycles.
    task automatic drive(input logic cs_n, dc, rw, en,
        input logic [7:0] d, input logic den, input int n);
        @(posedge mclk_i);
        select_n_o <= cs_n;
        dc_o <= dc;
        rw_o <= rw;
        en_o <= en;
        // A released bus shows the inverse of its last value, so it flips
        // with each released phase and a reader that samples it by mistake sees it move.
        bus_o <= den ? d : ~bus_o;
        bus_en_o <= den;
        repeat (n - 1) @(posedge mclk_i);
    endtask : drive

    // Serial byte, MSB first; the link clock rests low between bytes.
    task automatic ser_byte(input logic [7:0] d, input logic dc);
        for (int i = 7; i >= 0; i--) begin
            drive(1'h0, dc, 1'h0, 1'h0, {6'h00, d[i], 1'h0}, 1'h1, 4);
            drive(1'h0, dc, 1'h0, 1'h0, {6'h00, d[i], 1'h1}, 1'h1, 4);
        end
        drive(1'h0, dc, 1'h0, 1'h0, 8'h00, 1'h1, 6);
    endtask : ser_byte
endmodule : ohp_host_model

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ohp_pkg::*;
    logic mclk_i, rst_b_i, ext_reset_n, sel_lo, sel_hi, ok;
    logic cs_n, dc, rw, en, den, oe_n, rd_req, rd_dc, wr_v, wr_dc, init;
    logic oe_mid, oe_end;
    logic [7:0] rd_data, bus_o, dev_o, bus_in, wr_data, bus_mid;
    logic [8:0] wr_last;
    int n_errors = 0, n_tests = 0, n_wr = 0, n_rd = 0, cyc = 0, b;

    // The device wins the bus only while its enable is low.
    assign bus_in = (oe_n === 1'h0) ? dev_o : bus_o;

    ohp_host_model u_host (.mclk_i(mclk_i), .select_n_o(cs_n),
        .dc_o(dc), .rw_o(rw), .en_o(en), .bus_o(bus_o), .bus_en_o(den));

    ohp_host_port u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .ext_reset_n_i(ext_reset_n), .host_select_n_i(cs_n),
        .data_cmd_sel_i(dc), .rw_dir_i(rw), .enable_strobe_i(en),
        .iface_sel_lo_i(sel_lo), .iface_sel_hi_i(sel_hi),
        .host_bus_i(bus_in), .host_bus_o(dev_o), .host_bus_oe_n_o(oe_n),
        .rd_data_i(rd_data), .rd_req_o(rd_req), .rd_dc_o(rd_dc),
        .wr_valid_o(wr_v), .wr_dc_o(wr_dc), .wr_data_o(wr_data),
        .init_o(init));

    // Free-running 125 MHz clock.
    initial begin
        mclk_i = 1'h0;
        forever #4 mclk_i = ~mclk_i;
    end

    // Record pulses at the falling edge, away from the edge that moves
    // them, catch both sides driving the bus, and cut a hang short.
    always @(negedge mclk_i) begin
        cyc <= cyc + 1;
        if (den === 1'h1 && oe_n === 1'h0) begin
            n_errors++;
            $display("[FAIL] %0t bus driven by both sides", $time);
        end
        if (wr_v === 1'h1) begin
            n_wr <= n_wr + 1;
            wr_last <= {wr_dc, wr_data};
        end
        if (rd_req === 1'h1) begin
            n_rd <= n_rd + 1;
        end
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    task check(input logic okv, input string m);
        n_tests++;
        if (okv !== 1'h1) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : check

    // One parallel cycle: idle, active and idle strobe phases.
    task xfer(input logic m80, rd, dcv, input logic [7:0] d, input logic cs);
        u_host.drive(cs, dcv, m80 | rd, m80, d, ~rd, 4);
        u_host.drive(cs, dcv, rd, ~(m80 & rd), d, ~rd, 8);
        #1 oe_mid = oe_n;
        bus_mid = dev_o;
        u_host.drive(cs, dcv, m80 | rd, m80, d, ~rd, 6);
        #1 oe_end = oe_n;
    endtask : xfer

    // Straps pass a two-flop sync, so let them settle.
    task mode(input logic hi, lo);
        @(posedge mclk_i);
        sel_hi <= hi;
        sel_lo <= lo;
        repeat (5) @(posedge mclk_i);
    endtask : mode

    task t_init;
        @(posedge mclk_i);
        ext_reset_n <= 1'h0;
        repeat (4) @(posedge mclk_i);
        check(init === 1'h1, "init not raised");
        b = n_wr;
        xfer(1'h0, 1'h0, 1'h1, 8'h11, 1'h0);
        check(n_wr == b, "write taken in init");
        @(posedge mclk_i);
        ext_reset_n <= 1'h1;
        repeat (4) @(posedge mclk_i);
        check(init === 1'h0, "init stuck");
        $display("init test done");
    endtask : t_init

    task t_write(input logic m80);
        for (int k = 0; k < 2; k++) begin
            b = n_wr;
            xfer(m80, 1'h0, k[0], 8'hA5 ^ 8'(k), 1'h0);
            ok = n_wr == b + 1 && wr_last === {k[0], 8'hA5 ^ 8'(k)};
            check(ok, "write wrong");
            check(oe_mid & oe_end, "bus driven in write");
        end
        $display("write test done");
    endtask : t_write

    task t_read(input logic m80);
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk_i);
            rd_data <= 8'hC3 ^ 8'(k);
            b = n_rd;
            xfer(m80, 1'h1, k[0], 8'h00, 1'h0);
            ok = n_rd == b + 1 && rd_dc === k[0] && oe_mid === 1'h0;
            check(ok, "read not started");
            ok = bus_mid === (8'hC3 ^ 8'(k)) && oe_end === 1'h1;
            check(ok, "read data wrong");
        end
        $display("read test done");
    endtask : t_read

    task t_refuse;
        b = n_wr;
        mode(1'h1, 1'h0);
        xfer(1'h0, 1'h0, 1'h1, 8'h5A, 1'h1);
        check(n_wr == b, "taken while deselected");
        mode(1'h0, 1'h1);
        xfer(1'h0, 1'h0, 1'h1, 8'h5A, 1'h0);
        check(n_wr == b, "taken in dead mode");
        $display("refuse test done");
    endtask : t_refuse

    task t_serial;
        mode(1'h0, 1'h0);
        for (int k = 0; k < 2; k++) begin
            b = n_wr;
            u_host.ser_byte(8'hB4 ^ 8'(k * 255), ~k[0]);
            ok = n_wr == b + 1 && wr_last === {~k[0], 8'hB4 ^ 8'(k * 255)};
            check(ok, "serial byte wrong");
        end
        $display("serial test done");
    endtask : t_serial

    task results;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Main sequence; 68 straps first, then 80, refusals and serial.
    initial begin
        rst_b_i = 1'h0;
        ext_reset_n = 1'h1;
        sel_hi = 1'h1;
        sel_lo = 1'h0;
        rd_data = 8'h00;
        repeat (20) @(posedge mclk_i);
        rst_b_i <= 1'h1;
        t_init();
        t_write(1'h0);
        t_read(1'h0);
        mode(1'h1, 1'h1);
        t_write(1'h1);
        t_read(1'h1);
        t_refuse();
        t_serial();
        results();
    end
endmodule : testbench
